// ===== logic/lsd_core.v
// LED sink driver control: error flags, resets, PWM, reset call.
// Assumes analog sense inputs already in core clock domain except bus
// pins, which are synchronised here.
`timescale 1ns/10ps
`include "lsd_defines.vh"
module lsd_core #(
  parameter CH = 8,
  parameter GRP_STEP_CYC = `LSD_GRP_STEP_CYC,
  parameter BLINK_STEP_CYC = `LSD_BLINK_STEP_CYC
) (
  // Clock and resets
  input wire clock_in,
  input wire rst_n_in,
  input wire reset_pin_n_in,
  // Serial bus pins
  input wire scl_in,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe_n_out,
  // Channel control
  input wire [CH-1:0] channel_enable_in,
  input wire [8*CH-1:0] channel_duty_value_in,
  input wire [7:0] group_duty_value_in,
  input wire [7:0] group_blink_period_in,
  input wire [7:0] second_mode_register_in,
  // Sense inputs
  input wire [CH-1:0] current_below_threshold_in,
  input wire global_overtemp_in,
  input wire [CH-1:0] channel_overtemp_in,
  // Status and outputs
  output reg [CH-1:0] error_flag_register_out,
  output reg [CH-1:0] led_n_out,
  output reg active_mode_out,
  output reg soft_reset_out
);
  localparam ST_IDLE = 3'd0;
  localparam ST_ADDR = 3'd1;
  localparam ST_ACK = 3'd2;
  localparam ST_DATA = 3'd3;
  localparam ST_IGNORE = 3'd4;
  localparam OSC_DIV = `LSD_OSC_DIV;

  // Operating notes
  // Three reset sources reach this logic.
  // The async input is the power-on reset.
  // The reset pin is a level, synchronised first.
  // The pin and the reset call share one clear.
  // That clear is synchronous, so no async path
  // is ever fed from logic; no reset glitches.
  // The reset call clear lasts a single cycle.
  // The pin clear lasts while the pin stays low.
  //
  // Bus side
  // Clock and data pins pass two flip-flops.
  // Edges are found on the synchronised levels.
  // Both lines share the same sync depth, so
  // their order is kept within one core cycle.
  // A data change with the clock high is a
  // control condition, never a data bit.
  // Bits are taken on the clock rise only.
  // The receiver only parses the reset call;
  // any other address leaves it silent.
  // Acknowledge starts on the clock fall after
  // the eighth bit, so the data line never
  // moves while the clock is high.
  // Acknowledge ends on the following fall,
  // which closes the ninth clock pulse.
  // The drive is open-drain: data out is held
  // low and only the enable toggles.
  // Limitation: bus clock high and low phases
  // must each span at least three core cycles.
  //
  // Reset call arming
  // The call arms only after three good bytes.
  // A further full byte disarms it again.
  // Arming fires only on a stop condition.
  // A repeated start drops any arming.
  // The reset pulse clears all but the pin synchronisers and the bus output flops.
  //
  // Time bases
  // The core clock is divided to the step rate
  // of the internal oscillator.
  // The channel counter steps once per tick,
  // so a duty count maps to one tick.
  // The group counter uses its own prescaler.
  // In dimming mode the prescale is fixed.
  // In blinking mode each group step is
  // stretched by the programmed period plus 1.
  // The mode bit is read live; a change takes
  // effect on the running prescaler count at once.
  //
  // Channel gating
  // A channel sinks only while enabled, cool,
  // inside its duty window and inside the
  // group window; either group signal gates.
  // Sensor shutdown needs no latch; it lifts
  // by itself once the sensor cools.
  //
  // Error flags
  // A flag of 1 means normal, 0 means fault.
  // A disabled channel always reads 0.
  // Overheat faults are latched per channel.
  // Only enabled channels can latch them.
  // The clear bit wins while held at 1, and
  // blocks new latching until written back 0.
  // Open-load is reported live, not latched.
  //
  // Outputs
  // Every output is a flip-flop; channel outputs
  // lag their inputs one cycle, bus-driven outputs four.
  // Trade-off: one cycle of latency bought a
  // glitch-free drive on every pin.

  // Pin synchronisers
  reg [1:0] scl_sync_reg;
  reg [1:0] sda_sync_reg;
  reg [1:0] rpin_sync_reg;
  reg scl_prev_reg;
  reg sda_prev_reg;
  wire scl_s = scl_sync_reg[1];
  wire sda_s = sda_sync_reg[1];
  wire pin_rst = ~rpin_sync_reg[1];

  always @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      scl_sync_reg <= 2'b11;
      sda_sync_reg <= 2'b11;
      rpin_sync_reg <= 2'b00;
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], scl_in};
      sda_sync_reg <= {sda_sync_reg[0], sda_in};
      rpin_sync_reg <= {rpin_sync_reg[0], reset_pin_n_in};
      scl_prev_reg <= scl_s;
      sda_prev_reg <= sda_s;
    end
  end

  // Bus conditions from sampled levels
  wire scl_rise = scl_s & ~scl_prev_reg;
  wire scl_fall = ~scl_s & scl_prev_reg;
  wire start_c = scl_s & scl_prev_reg & sda_prev_reg & ~sda_s;
  wire stop_c = scl_s & scl_prev_reg & ~sda_prev_reg & sda_s;

  // Reset call receiver
  reg [2:0] state_reg;
  reg [2:0] bitcnt_reg;
  reg [7:0] shift_reg;
  reg [1:0] byte_idx_reg;
  reg armed_reg;
  reg ack_drive_reg;
  reg soft_rst_reg;
  wire [7:0] byte_now = {shift_reg[6:0], sda_s};
  wire sync_clear = pin_rst | soft_rst_reg;

  function byte_ok;
    input [1:0] idx;
    input [7:0] b;
    begin
      case (idx)
        2'd0: byte_ok = (b == `LSD_RST_ADDR_BYTE);
        2'd1: byte_ok = (b == `LSD_RST_BYTE1);
        2'd2: byte_ok = (b == `LSD_RST_BYTE2);
        default: byte_ok = 1'b0;
      endcase
    end
  endfunction

  // Byte shifting and acknowledge decision
  always @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= ST_IDLE;
      bitcnt_reg <= 3'd0;
      shift_reg <= 8'h00;
      byte_idx_reg <= 2'd0;
      armed_reg <= 1'b0;
      ack_drive_reg <= 1'b0;
      soft_rst_reg <= 1'b0;
    end else if (sync_clear) begin
      state_reg <= ST_IDLE;
      bitcnt_reg <= 3'd0;
      shift_reg <= 8'h00;
      byte_idx_reg <= 2'd0;
      armed_reg <= 1'b0;
      ack_drive_reg <= 1'b0;
      soft_rst_reg <= 1'b0;
    end else if (start_c) begin
      state_reg <= ST_ADDR;
      bitcnt_reg <= 3'd0;
      byte_idx_reg <= 2'd0;
      armed_reg <= 1'b0;
      ack_drive_reg <= 1'b0;
    end else if (stop_c) begin
      // Only a fully acknowledged call fires the reset
      soft_rst_reg <= armed_reg;
      state_reg <= ST_IDLE;
      armed_reg <= 1'b0;
      ack_drive_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_ADDR, ST_DATA: begin
          if (scl_rise) begin
            shift_reg <= byte_now;
            bitcnt_reg <= bitcnt_reg + 3'd1;
            if (bitcnt_reg == 3'd7) begin
              if (byte_ok(byte_idx_reg, byte_now)) begin
                // Drive waits for the clock fall; pulling data
                // low with the clock high would look like start
                ack_drive_reg <= 1'b0;
                armed_reg <= (byte_idx_reg == 2'd2);
                state_reg <= ST_ACK;
              end else begin
                // Anything wrong aborts the call silently
                armed_reg <= 1'b0;
                state_reg <= ST_IGNORE;
              end
            end
          end
        end
        ST_ACK: begin
          // Hold acknowledge through the ninth clock pulse
          if (scl_fall & (bitcnt_reg == 3'd0)) begin
            // Clock is low now, safe to pull data
            ack_drive_reg <= 1'b1;
            bitcnt_reg <= 3'd1;
          end else if (scl_fall & (bitcnt_reg == 3'd1)) begin
            ack_drive_reg <= 1'b0;
            bitcnt_reg <= 3'd0;
            byte_idx_reg <= byte_idx_reg + 2'd1;
            state_reg <= (byte_idx_reg == 2'd2) ? ST_IGNORE : ST_DATA;
          end
        end
        ST_IGNORE: begin
          ack_drive_reg <= 1'b0;
          // A whole extra byte makes the call malformed
          if (scl_rise) begin
            bitcnt_reg <= bitcnt_reg + 3'd1;
            if (bitcnt_reg == 3'd7) begin
              armed_reg <= 1'b0;
            end
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Open-drain data pin, enable low while pulling low
  always @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sda_out <= 1'b1;
      sda_oe_n_out <= 1'b1;
      soft_reset_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
      sda_oe_n_out <= ~ack_drive_reg;
      soft_reset_out <= soft_rst_reg;
    end
  end

  // Oscillator tick and group time bases
  reg [3:0] osc_cnt_reg;
  reg [7:0] pwm_cnt_reg;
  reg [15:0] grp_pre_reg;
  reg [7:0] grp_cnt_reg;
  reg [7:0] blink_step_reg;
  wire osc_tick = (osc_cnt_reg == OSC_DIV - 1);
  wire blink_mode = second_mode_register_in[`LSD_SECOND_MODE_REGISTER_BLINK_BIT];
  wire [15:0] grp_lim = blink_mode ? BLINK_STEP_CYC[15:0] :
                                     GRP_STEP_CYC[15:0];
  wire grp_tick = (grp_pre_reg == grp_lim - 16'd1);

  always @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      osc_cnt_reg <= 4'd0;
      pwm_cnt_reg <= 8'd0;
      grp_pre_reg <= 16'd0;
      grp_cnt_reg <= 8'd0;
      blink_step_reg <= 8'd0;
    end else if (sync_clear) begin
      osc_cnt_reg <= 4'd0;
      pwm_cnt_reg <= 8'd0;
      grp_pre_reg <= 16'd0;
      grp_cnt_reg <= 8'd0;
      blink_step_reg <= 8'd0;
    end else begin
      // 256 oscillator steps give the 97 kHz frame
      osc_cnt_reg <= osc_tick ? 4'd0 : osc_cnt_reg + 4'd1;
      if (osc_tick) begin
        pwm_cnt_reg <= pwm_cnt_reg + 8'd1;
      end
      grp_pre_reg <= grp_tick ? 16'd0 : grp_pre_reg + 16'd1;
      if (grp_tick) begin
        // Blink steps stretch each group count by period+1
        if (blink_mode && blink_step_reg != group_blink_period_in) begin
          blink_step_reg <= blink_step_reg + 8'd1;
        end else begin
          blink_step_reg <= 8'd0;
          grp_cnt_reg <= grp_cnt_reg + 8'd1;
        end
      end
    end
  end

  // Channel gating, shutdown and error latching
  reg [CH-1:0] ot_latch_reg;
  reg [CH-1:0] on_w;
  reg [CH-1:0] err_w;
  reg [CH-1:0] ot_set;
  integer i;
  wire grp_on = grp_cnt_reg < group_duty_value_in;
  wire ot_clear = second_mode_register_in[`LSD_SECOND_MODE_REGISTER_OT_CLR_BIT];

  always @* begin
    on_w = {CH{1'b0}};
    err_w = {CH{1'b0}};
    ot_set = {CH{1'b0}};
    for (i = 0; i < CH; i = i + 1) begin
      // Shutdown releases by itself once sensors cool
      on_w[i] = channel_enable_in[i] & ~global_overtemp_in &
                ~channel_overtemp_in[i] &
                (pwm_cnt_reg < channel_duty_value_in[8*i +: 8]) &
                grp_on;
      ot_set[i] = channel_enable_in[i] &
                  (global_overtemp_in | channel_overtemp_in[i]);
      err_w[i] = ~channel_enable_in[i] | ot_latch_reg[i] | ot_set[i] |
                 current_below_threshold_in[i];
    end
  end

  // Latched overheat errors; clear bit clears and blocks latching
  always @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ot_latch_reg <= {CH{1'b0}};
      error_flag_register_out <= {CH{1'b0}};
      led_n_out <= {CH{1'b1}};
      active_mode_out <= 1'b0;
    end else if (sync_clear) begin
      ot_latch_reg <= {CH{1'b0}};
      error_flag_register_out <= {CH{1'b0}};
      led_n_out <= {CH{1'b1}};
      active_mode_out <= 1'b0;
    end else begin
      if (ot_clear) begin
        ot_latch_reg <= {CH{1'b0}};
      end else begin
        ot_latch_reg <= ot_latch_reg | ot_set;
      end
      error_flag_register_out <= ~err_w;
      led_n_out <= ~on_w;
      active_mode_out <= |channel_enable_in;
    end
  end
endmodule // lsd_core

// ===== logic/lsd_defines.vh
// Constants for the LED sink driver control block.
// Assumes a 200 MHz core clock; included by its bare name.
// What this block does
// - On channel, low current reads status 0
// - Off channel status bit reads 0
// - Global overheat shuts all, latches errors of enabled channels
// - Restart when cool; latched error stays
// - Channel overheat shuts that channel only
// - Channel overheat checked only when on
// - Error flag ORs open-load and overheat
// - Mode bit 7 clears, then re-enables flagging
// - Power-on reset zeroes registers and bus
// - Reset pin low holds defaults
// - Acknowledge reset address 96h write only
// - First byte acknowledged only if A5h
// - Second byte acknowledged only if 5Ah
// - No acknowledge beyond second byte
// - Stop after good call resets device
// - Malformed call leaves registers untouched
// - 97 kHz channel PWM, 40 ns steps
// - 190 Hz group dimming, 20.48 us steps
// - Blink period programmable 95 Hz to 2.68 s
// - Output active only when both signals active
// - Active when any channel enabled, else standby
// - Sample bits on clock; start and stop
// - Completed call acts as power-on reset
`ifndef LSD_DEFINES_VH
`define LSD_DEFINES_VH
`define LSD_RST_ADDR_BYTE 8'h96
`define LSD_RST_BYTE1 8'hA5
`define LSD_RST_BYTE2 8'h5A
`define LSD_SECOND_MODE_REGISTER_OT_CLR_BIT 7
`define LSD_SECOND_MODE_REGISTER_BLINK_BIT 5
`define LSD_CLK_MHZ 200
`define LSD_OSC_MHZ 25
`define LSD_OSC_DIV (`LSD_CLK_MHZ / `LSD_OSC_MHZ)
`define LSD_PWM_STEP_NS 40
`define LSD_GRP_STEP_NS 20480
`define LSD_GRP_STEP_CYC ((`LSD_GRP_STEP_NS * `LSD_CLK_MHZ) / 1000)
`define LSD_BLINK_STEP_CYC 8192
`endif

// ===== test/lsd_core_sva.sv
// Port checker for the LED sink driver control block.
// Bound into every lsd_core; sees only that module's ports.
`timescale 1ns/10ps
module lsd_core_sva #(
  parameter CH = 8,
  parameter GRP_STEP_CYC = 4,
  parameter BLINK_STEP_CYC = 8
) (
  // Clock, resets and the serial answer
  input wire clock_in,
  input wire rst_n_in,
  input wire reset_pin_n_in,
  input wire sda_out,
  input wire sda_oe_n_out,
  // Channel side
  input wire [CH-1:0] channel_enable_in,
  input wire [7:0] second_mode_register_in,
  input wire [CH-1:0] current_below_threshold_in,
  input wire global_overtemp_in,
  input wire [CH-1:0] error_flag_register_out,
  input wire [CH-1:0] led_n_out,
  input wire active_mode_out,
  input wire soft_reset_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  // Flags lag their causes by the one output register stage
  a_off_flag_low: assert property (
    (error_flag_register_out & ~$past(channel_enable_in)) == 0)
    else $error("flag high on a disabled channel");
  a_open_load_low: assert property (
    (error_flag_register_out & $past(current_below_threshold_in)) == 0)
    else $error("flag high with low current");
  a_global_shut: assert property (
    global_overtemp_in [*3] |-> &led_n_out && error_flag_register_out == 0)
    else $error("global overheat left a channel running");
  a_latch_holds: assert property (
    $fell(global_overtemp_in) && !second_mode_register_in[7]
    |-> ##1 (error_flag_register_out == 0) [*3])
    else $error("overheat error cleared on cooling");
  // Soft reset briefly clears the mode output, so skip that window
  a_standby_mode: assert property (
    reset_pin_n_in [*5] ##0 !soft_reset_out [*3] ##0 $past(rst_n_in, 4)
    |-> active_mode_out == (|$past(channel_enable_in)))
    else $error("active mode does not follow enables");
  a_pin_holds: assert property (
    !reset_pin_n_in [*4] |-> &led_n_out && !active_mode_out
    && error_flag_register_out == 0)
    else $error("reset pin low did not hold defaults");
  a_ack_low: assert property (
    !sda_oe_n_out |-> !sda_out)
    else $error("device drove data high");
  a_ack_ends: assert property (
    $fell(sda_oe_n_out) |-> ##[1:40] sda_oe_n_out)
    else $error("acknowledge held too long");
  a_reset_pulse: assert property (
    soft_reset_out |=> !soft_reset_out)
    else $error("soft reset longer than one cycle");
  a_reset_leds: assert property (
    soft_reset_out |-> ##[0:1] &led_n_out)
    else $error("soft reset left an LED on");
  // Main scenarios reached
  c_soft_reset: cover property (soft_reset_out);
  c_ack: cover property (!sda_oe_n_out);
  c_cooled: cover property ($fell(global_overtemp_in));
endmodule // lsd_core_sva

bind lsd_core lsd_core_sva #(
  .CH(CH),
  .GRP_STEP_CYC(GRP_STEP_CYC),
  .BLINK_STEP_CYC(BLINK_STEP_CYC)
) u_sva (.*);

// ===== test/lsd_bus_master.sv
// Serial bus master model: start, bytes with ack, stop.
// Assumes a pull-up merges its data drive with the device's.
`timescale 1ns/10ps
module lsd_bus_master (
  output logic scl_out,
  output logic sda_drv_out,
  input wire logic sda_line_in
);
  // Idle bus: both lines high, clock stands still
  initial begin
    scl_out = 1'b1;
    sda_drv_out = 1'b1;
  end
  // Data falls while clock high; 48 ns link period
  task automatic start_cond();
    sda_drv_out = 1'b1;
    #12 scl_out = 1'b1;
    #24 sda_drv_out = 1'b0;
    #24 scl_out = 1'b0;
  endtask
  // Data rises while clock high, bus left free
  task automatic stop_cond();
    #12 sda_drv_out = 1'b0;
    #12 scl_out = 1'b1;
    #24 sda_drv_out = 1'b1;
    #24;
  endtask
  // MSB first, then a released ninth pulse for the ack
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      #12 sda_drv_out = b[i];
      #12 scl_out = 1'b1;
      #24 scl_out = 1'b0;
    end
    #12 sda_drv_out = 1'b1;
    #12 scl_out = 1'b1;
    #12 ack = ~sda_line_in;
    #12 scl_out = 1'b0;
  endtask
endmodule // lsd_bus_master

// ===== test/tb_lsd_core.sv
// Testbench for lsd_core: flags, resets, PWM and the reset call.
// Drives the bus via lsd_bus_master; short group step counts.
`timescale 1ns/10ps
module tb_lsd_core;
  // Stimulus and observed signals
  logic clock_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic pin_n = 1'b1;
  logic gtemp = 1'b0;
  logic [7:0] en = 8'h00, cur = 8'h00, cot = 8'h00, mode = 8'h00;
  logic [7:0] gduty = 8'h00, gblink = 8'h01;
  logic [63:0] duty = {8{8'h00}};
  wire scl, sda_drv, sda_o, sda_oe_n, active, srst;
  wire [7:0] error_flag_register, led_n;
  wire sda = sda_drv & (sda_oe_n | sda_o); // Pull-up unless pulled
  int err_total = 0, n_compared = 0, n_srst = 0;

  lsd_core #(.GRP_STEP_CYC(4), .BLINK_STEP_CYC(8)) dut (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .reset_pin_n_in(pin_n),
    .scl_in(scl), .sda_in(sda), .sda_out(sda_o), .sda_oe_n_out(sda_oe_n),
    .channel_enable_in(en), .channel_duty_value_in(duty),
    .group_duty_value_in(gduty), .group_blink_period_in(gblink),
    .second_mode_register_in(mode), .current_below_threshold_in(cur),
    .global_overtemp_in(gtemp), .channel_overtemp_in(cot),
    .error_flag_register_out(error_flag_register), .led_n_out(led_n),
    .active_mode_out(active), .soft_reset_out(srst));
  lsd_bus_master m (.scl_out(scl), .sda_drv_out(sda_drv),
    .sda_line_in(sda));

  // 200 MHz core clock
  initial forever #2.5 clock_in = ~clock_in;
  // Soft reset pulses seen
  always @(posedge clock_in) if (srst === 1'b1) n_srst++;

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
  endtask
  // LED 0 on-cycles, sampled mid-cycle once settled
  task automatic count(input int n, output int c);
    c = 0;
    repeat (n) begin
      @(negedge clock_in);
      if (led_n[0] === 1'b0) c++;
    end
  endtask
  task automatic clear_ot();
    mode <= 8'h80;
    tick(3);
    mode <= 8'h00;
    tick(4);
  endtask
  // One framed call; bytes from the top, acks against want
  task automatic call(input logic [31:0] b, input int nb,
      input logic [3:0] want);
    logic k;
    m.start_cond();
    for (int i = 0; i < nb; i++) begin
      m.send_byte(b[31-8*i -: 8], k);
      check({7'h00, k}, {7'h00, want[3-i]});
    end
    m.stop_cond();
    tick(20);
  endtask
  task automatic tally_and_finish();
    $display("compared %0d mismatched %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Hang guard, well past the expected run
  initial begin
    #300000;
    err_total++;
    tally_and_finish();
  end

  initial begin
    int c;
    tick(12);
    rst_n_in <= 1'b1;
    tick(4);
    check(led_n, 8'hFF);
    check({error_flag_register[6:0], active}, 8'h00);
    en <= 8'h0F;
    cur <= 8'h01;
    cot <= 8'h12;
    tick(4);
    check(error_flag_register, 8'h0C);
    en <= 8'h1F;
    cot <= 8'h00;
    tick(4);
    check(error_flag_register, 8'h1C);
    clear_ot();
    check(error_flag_register, 8'h1E);
    $display("flag test done");
    cur <= 8'h00;
    duty <= {8{8'hFF}};
    gduty <= 8'hFF;
    gtemp <= 1'b1;
    tick(4);
    check(error_flag_register | ~led_n, 8'h00);
    gtemp <= 1'b0;
    tick(4);
    check(error_flag_register, 8'h00);
    count(2048, c);
    check({7'h00, c > 1000}, 8'h01);
    clear_ot();
    check(error_flag_register, 8'h1F);
    $display("overheat test done");
    duty <= {8{8'h04}};
    tick(2100);
    count(4096, c);
    check({7'h00, c >= 56 && c <= 64}, 8'h01);
    duty <= {8{8'hFF}};
    gduty <= 8'h80;
    for (int i = 0; i < 2; i++) begin
      mode <= i ? 8'h20 : 8'h00;
      tick(4200);
      count(4096, c);
      check({7'h00, c > 1900 && c <= 2048}, 8'h01);
    end
    gduty <= 8'h00;
    tick(4200);
    count(2048, c);
    check({7'h00, c == 0}, 8'h01);
    $display("pwm test done");
    cot <= 8'h04;
    tick(2);
    cot <= 8'h00;
    call(32'h97A5_5A00, 3, 4'h0);
    call(32'h96A4_5A00, 3, 4'h8);
    call(32'h96A5_5B00, 3, 4'hC);
    call(32'h96A5_5AA5, 4, 4'hE);
    check({error_flag_register[6:0], n_srst[0]}, 8'h36);
    call(32'h96A5_5A00, 3, 4'hE);
    check(n_srst[7:0], 8'h01);
    check(error_flag_register, 8'h1F);
    $display("reset call test done");
    pin_n <= 1'b0;
    tick(6);
    check({led_n[6:0], active}, 8'hFE);
    pin_n <= 1'b1;
    tick(6);
    check({7'h00, active}, 8'h01);
    $display("reset pin test done");
    tally_and_finish();
  end
endmodule // tb_lsd_core
